// *** hdl/cbg_guard.sv ***
/*
 * chopper blanking, overcurrent and short guard for two bridges.
 * assumes synchronous comparator and pin inputs and a one-cycle
 * osc_tick_in at the start of every chopper pwm cycle.
 */
`timescale 1ns/1ns
module cbg_guard (
	// clock and reset
	input  wire logic                clk_in,
	input  wire logic                rst_in,
	// configuration pins
	input  wire logic                blank_select_low_bit_in,
	input  wire logic                blank_select_high_bit_in,
	input  wire logic                driver_disable_input_in,
	input  wire logic                coil_a_polarity_in,
	input  wire logic                coil_b_polarity_in,
	input  wire logic                coil_a_mixed_decay_off_in,
	input  wire logic                coil_b_mixed_decay_off_in,
	// serial command side
	input  wire logic                serial_dir_a_in,
	input  wire logic                serial_dir_b_in,
	input  wire logic                cmd_valid_in,
	input  wire logic                cmd_both_zero_in,
	// analog comparators and oscillator
	input  wire logic                osc_tick_in,
	input  wire logic                chop_cmp_a_in,
	input  wire logic                chop_cmp_b_in,
	input  wire logic                coil_a_sense_input_in,
	input  wire logic                coil_b_sense_input_in,
	input  wire logic                high_side_sense_node_in,
	input  wire logic                overtemp_in,
	// register port
	input  wire logic [7:0]          reg_addr_in,
	input  wire logic [31:0]         reg_wdata_in,
	input  wire logic                reg_wr_in,
	input  wire logic                reg_rd_in,
	output logic      [31:0]         reg_rdata_out,
	// bridge drive
	output cbg_pkg::cbg_drive_s      drive_a_out,
	output cbg_pkg::cbg_drive_s      drive_b_out,
	output logic                     mixed_decay_a_out,
	output logic                     mixed_decay_b_out,
	output cbg_pkg::cbg_status_s     status_out
);

	// ------------------------------------------------------------------
	// registers and shared state
	// ------------------------------------------------------------------
	logic        standalone;
	logic        next_standalone;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic        overtemp;
	logic [1:0]  dir;
	logic [1:0]  next_dir;
	logic [3:0]  blank_cnt [2];
	logic [1:0]  err_cnt   [3];
	logic [6:0]  clean_cnt [3];
	logic [5:0]  lock_cnt  [3];
	logic [2:0]  err_flag;
	logic [2:0]  rest_off;
	logic [1:0]  chop_term;
	logic [3:0]  blank_len;
	logic [1:0]  blank;
	logic [1:0]  on;
	logic [1:0]  sw_evt;
	logic [2:0]  oc_evt;
	logic [1:0]  sense;
	logic [1:0]  chop_cmp;
	logic [1:0]  chop_evt;
	logic        flag_clr;

	// ------------------------------------------------------------------
	// blank length select and common terms
	// ------------------------------------------------------------------
	always_comb begin
		case ({blank_select_high_bit_in, blank_select_low_bit_in}) // [R1]
			2'h0:    blank_len = cbg_pkg::BLANK_00_CYC;
			2'h1:    blank_len = cbg_pkg::BLANK_01_CYC;
			2'h2:    blank_len = cbg_pkg::BLANK_10_CYC;
			default: blank_len = cbg_pkg::BLANK_11_CYC;
		endcase
	end

	assign sense    = {coil_b_sense_input_in, coil_a_sense_input_in};
	assign chop_cmp = {chop_cmp_b_in, chop_cmp_a_in};
	assign flag_clr = driver_disable_input_in | (cmd_valid_in & cmd_both_zero_in); // [R11]

	always_comb begin
		next_dir = {serial_dir_b_in, serial_dir_a_in};
		if (standalone) begin
			next_dir = {coil_b_polarity_in, coil_a_polarity_in}; // [R16]
		end
	end

	// ------------------------------------------------------------------
	// per-bridge blanking and drive
	// ------------------------------------------------------------------
	for (genvar b = 0; b < 2; b++) begin : g_bridge
		logic [3:0] next_blank;
		logic       next_chop;

		assign sw_evt[b]   = osc_tick_in | (next_dir[b] != dir[b]);
		assign blank[b]    = blank_cnt[b] != 4'h0;
		assign chop_evt[b] = chop_cmp[b] & ~blank[b] & on[b]; // [R2]
		assign oc_evt[b]   = sense[b] & ~blank[b] & on[b] & ~rest_off[b]; // [R3] [R8]
		assign on[b] = ~driver_disable_input_in & ~overtemp // [R13] [R14] [R15]
			& ~rest_off[b] & ~rest_off[2] & ~chop_term[b] // [R10]
			& (lock_cnt[b] == 6'h0) & (lock_cnt[2] == 6'h0); // [R5]

		always_comb begin
			next_blank = blank_cnt[b];
			next_chop  = chop_term[b];
			if (sw_evt[b]) begin
				next_blank = blank_len; // [R21]
			end else if (blank[b]) begin
				next_blank = blank_cnt[b] - 4'h1;
			end
			if (osc_tick_in) begin
				next_chop = 1'b0;
			end
			if (chop_evt[b]) begin
				next_chop = 1'b1;
			end
		end

		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				blank_cnt[b] <= 4'h0;
				chop_term[b] <= 1'b0;
			end else begin
				blank_cnt[b] <= next_blank;
				chop_term[b] <= next_chop;
			end
		end

		blank_len_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R1]
			(sw_evt[b] && blank_len == cbg_pkg::BLANK_00_CYC) |=> blank[b][*6])
			else $error("blank pulse shorter than selected");
		chop_mask_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
			(blank[b] && !sw_evt[b] && !osc_tick_in) |=> $stable(chop_term[b]))
			else $error("chopper cycle ended during blank");
		oc_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R3]
			(oc_evt[b] && !osc_tick_in) |=> (!on[b] && rest_off[b]))
			else $error("bridge still on after overcurrent");
		hs_both_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
			(oc_evt[2] && !osc_tick_in) |=> !on[b])
			else $error("bridge on after high side short");
		temp_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R13]
			($past(overtemp_in) && !$past(rst_in)) |-> !on[b])
			else $error("bridge on during overtemperature");
		disable_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R15]
			driver_disable_input_in |-> !on[b])
			else $error("bridge on while driver disabled");
		rest_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R3]
			(rest_off[b] && !osc_tick_in) |=> (rest_off[b] && !on[b]))
			else $error("bridge back on before cycle end");
		oc_blank_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R8]
			(blank[b] && !osc_tick_in) |=> err_cnt[b] == $past(err_cnt[b]))
			else $error("overcurrent counted during blank");
		lock_off_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R5]
			(lock_cnt[b] != 6'h0 || lock_cnt[2] != 6'h0) |-> !on[b])
			else $error("bridge on during lock-out");
		temp_resume_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R14]
			(!overtemp && $past(overtemp) && !driver_disable_input_in && !rest_off[b]
			&& !rest_off[2] && !chop_term[b] && lock_cnt[b] == 6'h0 && lock_cnt[2] == 6'h0)
			|-> on[b])
			else $error("bridge did not resume after cool-down");
	end

	// ------------------------------------------------------------------
	// error paths: bridge a, bridge b, high side
	// ------------------------------------------------------------------
	assign oc_evt[2] = high_side_sense_node_in & ~(blank[0] | blank[1]) // [R9]
		& (on[0] | on[1]) & ~rest_off[2];

	hs_blank_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R9]
		((blank[0] || blank[1]) && !osc_tick_in) |=> err_cnt[2] == $past(err_cnt[2]))
		else $error("high side short counted during blank");

	for (genvar p = 0; p < 3; p++) begin : g_path // [R7]
		logic [1:0] next_err;
		logic [6:0] next_clean;
		logic [5:0] next_lock;
		logic       next_flag;
		logic       next_rest;

		always_comb begin
			next_err   = err_cnt[p];
			next_clean = clean_cnt[p];
			next_lock  = lock_cnt[p];
			next_flag  = err_flag[p];
			next_rest  = rest_off[p];
			if (osc_tick_in) begin
				next_rest = 1'b0;
				if (lock_cnt[p] != 6'h0) begin
					next_lock = lock_cnt[p] - 6'h1; // [R21]
				end
				if (clean_cnt[p] != cbg_pkg::CLEAN_LIMIT) begin
					next_clean = clean_cnt[p] + 7'h1;
				end
				if (next_clean == cbg_pkg::CLEAN_LIMIT) begin
					next_err = 2'h0; // [R6]
				end
			end
			if (flag_clr) begin
				next_flag = 1'b0;
			end
			if (oc_evt[p]) begin
				next_rest  = 1'b1;
				next_clean = 7'h0;
				if (err_cnt[p] == cbg_pkg::ERR_LIMIT - 2'h1) begin
					next_err  = 2'h0;
					next_lock = cbg_pkg::LOCK_PWM_CYC; // [R5]
					next_flag = 1'b1;
				end else begin
					next_err = err_cnt[p] + 2'h1; // [R4]
				end
			end
		end

		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				err_cnt[p]   <= 2'h0;
				clean_cnt[p] <= 7'h0;
				lock_cnt[p]  <= 6'h0;
				err_flag[p]  <= 1'b0;
				rest_off[p]  <= 1'b0;
			end else begin
				err_cnt[p]   <= next_err;
				clean_cnt[p] <= next_clean;
				lock_cnt[p]  <= next_lock;
				err_flag[p]  <= next_flag;
				rest_off[p]  <= next_rest;
			end
		end

		err_step_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R4]
			(oc_evt[p] && err_cnt[p] < 2'h2 && !osc_tick_in) |=>
			err_cnt[p] == $past(err_cnt[p]) + 2'h1)
			else $error("error counter did not step by one");
		lock_set_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R5]
			(oc_evt[p] && err_cnt[p] == 2'h2) |=>
			(err_flag[p] && lock_cnt[p] == 6'h3f))
			else $error("third error did not lock bridge");
		clean_clr_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R6]
			(clean_cnt[p] == 7'h40) |-> (err_cnt[p] == 2'h0 || $past(oc_evt[p])))
			else $error("error count kept after clean period");
		flag_clear_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
			(flag_clr && !oc_evt[p]) |=> !err_flag[p])
			else $error("flag not cleared");
		lock_tick_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R21]
			(!osc_tick_in && !oc_evt[p]) |=> lock_cnt[p] == $past(lock_cnt[p]))
			else $error("lock-out counted outside pwm ticks");
	end

	// ------------------------------------------------------------------
	// register port and shared flops
	// ------------------------------------------------------------------
	always_comb begin
		next_standalone = standalone;
		next_rdata      = 32'h0;
		if (reg_wr_in && reg_addr_in == cbg_pkg::CTRL_OFS) begin
			next_standalone = reg_wdata_in[cbg_pkg::CTRL_STANDALONE_BIT];
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				cbg_pkg::CTRL_OFS:   next_rdata = {31'h0, standalone};
				cbg_pkg::STATUS_OFS: next_rdata = {25'h0, status_out};
				cbg_pkg::ERRCNT_OFS: next_rdata = {26'h0, err_cnt[2], err_cnt[1], err_cnt[0]};
				default:             next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			standalone <= cbg_pkg::CTRL_RESET;
			rdata      <= 32'h0;
			overtemp   <= 1'b0;
			dir        <= 2'h0;
		end else begin
			standalone <= next_standalone;
			rdata      <= next_rdata;
			overtemp   <= overtemp_in; // [R13] [R14]
			dir        <= next_dir;
		end
	end

	standalone_dir_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R16]
		standalone |=> dir == {$past(coil_b_polarity_in), $past(coil_a_polarity_in)})
		else $error("standalone polarity not followed");

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign reg_rdata_out     = rdata;
	assign drive_a_out       = '{on: on[0], dir: dir[0], blank: blank[0], chop_end: chop_term[0]};
	assign drive_b_out       = '{on: on[1], dir: dir[1], blank: blank[1], chop_end: chop_term[1]};
	assign mixed_decay_a_out = ~coil_a_mixed_decay_off_in;
	assign mixed_decay_b_out = ~coil_b_mixed_decay_off_in;
	assign status_out        = '{err_flag: err_flag, overtemp: overtemp,
		lock_active: {lock_cnt[2] != 6'h0, lock_cnt[1] != 6'h0, lock_cnt[0] != 6'h0}};

endmodule

// *** hdl/cbg_pkg.sv ***
/*
 * shared constants and carrier types for the chopper blanking and
 * overcurrent guard. assumes a 10 MHz system clock and a one-cycle
 * chopper cycle tick from the oscillator.
 */
// ----------------------------------------------------------------------
// Overview of operation
// R1: blank length from two select pins: 0.6, 0.9, 1.2, 1.5 us.
// R2: chopper comparators masked by blank pulse after every switching event.
// R3: low-side sense above threshold after blank ends cycle, bridge off.
// R4: each low-side overcurrent bumps that bridge's error counter by one.
// R5: counter reaching 3 holds bridge off 63 cycles and sets error flag.
// R6: more than 63 clean cycles clear the error counter.
// R7: one error counter per low-side bridge, one for high side.
// R8: overcurrent ignored while that bridge's blank pulse runs.
// R9: high-side short seen any time outside the ORed blank pulses.
// R10: high-side short turns off both bridges for rest of cycle.
// R11: flags cleared by disable/re-enable or zero current command.
// R12: host isolates high-side fault by driving one bridge at a time.
// R13: overtemperature turns all bridges off and raises its flag.
// R14: bridges resume by themselves once overtemperature clears.
// R15: disable input high shuts down the whole driver stage.
// R16: standalone mode takes coil polarity straight from polarity pins.
// R17: host keeps mixed-decay-off inputs high during voltage pwm.
// R18: host sets analog limit 20% to 30% above peak pwm current.
// R19: host adds offset 1 to sine amplitudes in serial mixed decay.
// R20: host watches pre-warning flag and lowers current.
// R21: blank counted in clock cycles, lock-out and clearing in pwm cycles.
// ----------------------------------------------------------------------
package cbg_pkg;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int BLANK_00_NS   = 600;
	localparam int BLANK_01_NS   = 900;
	localparam int BLANK_10_NS   = 1200;
	localparam int BLANK_11_NS   = 1500;
	localparam logic [3:0] BLANK_00_CYC = 4'((BLANK_00_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] BLANK_01_CYC = 4'((BLANK_01_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] BLANK_10_CYC = 4'((BLANK_10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] BLANK_11_CYC = 4'((BLANK_11_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [5:0] LOCK_PWM_CYC = 6'h3f;
	localparam logic [1:0] ERR_LIMIT    = 2'h3;
	localparam logic [6:0] CLEAN_LIMIT  = 7'h40;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] ERRCNT_OFS = 8'h08;
	localparam int CTRL_STANDALONE_BIT = 0;
	localparam logic CTRL_RESET = 1'h0;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic on;
		logic dir;
		logic blank;
		logic chop_end;
	} cbg_drive_s;

	typedef struct packed {
		logic [2:0] err_flag;
		logic       overtemp;
		logic [2:0] lock_active;
	} cbg_status_s;

endpackage

// *** sim/cbg_bridge_model.sv ***
/*
 * far-side model: two power bridges with their sense comparators.
 * assumes the bench raises fault requests; a bridge that is off
 * carries no current, so its comparators stay quiet.
 */
`timescale 1ns/1ns
module cbg_bridge_model (
	// bridge state
	input  wire logic on_a_in,
	input  wire logic on_b_in,
	// injected faults
	input  wire logic fault_a_in,
	input  wire logic fault_b_in,
	input  wire logic fault_hs_in,
	// comparators and host pins
	output logic      sense_a_out,
	output logic      sense_b_out,
	output logic      hs_out,
	output logic      decay_off_a_out,
	output logic      decay_off_b_out
);
	// ------------------------------------------------------------------
	// comparators
	// ------------------------------------------------------------------
	// limit set above peak drive current: trips on injected faults only
	assign sense_a_out = fault_a_in & on_a_in;
	assign sense_b_out = fault_b_in & on_b_in;
	assign hs_out      = fault_hs_in & (on_a_in | on_b_in);
	// ------------------------------------------------------------------
	// host pins
	// ------------------------------------------------------------------
	assign decay_off_a_out = 1'h1;
	assign decay_off_b_out = 1'h1;
endmodule

// *** sim/cbg_guard_bench.sv ***
/*
 * self-checking bench for the chopper guard.
 * assumes the bridge model answers the sense lines; bench drives pins.
 */
`timescale 1ns/1ns
module cbg_guard_bench;
	logic clk_in = 1'h0;
	logic rst_in = 1'h1;
	logic bl = 1'h0, bh = 1'h0, dis = 1'h0, pa = 1'h0, pb = 1'h0, sdb = 1'h1;
	logic cv = 1'h0, cz = 1'h0, osc = 1'h0, cha = 1'h0, chb = 1'h0, ot = 1'h0;
	logic fa = 1'h0, fb = 1'h0, fh = 1'h0, wr = 1'h0, rd = 1'h0;
	logic sa, sb, hs, da, db, ma, mb;
	logic [7:0] addr = 8'h00;
	logic [31:0] wd = 32'h0, rdat;
	cbg_pkg::cbg_drive_s dra, drb;
	cbg_pkg::cbg_status_s st;
	logic [3:0] blen [4] = '{cbg_pkg::BLANK_00_CYC, cbg_pkg::BLANK_01_CYC,
		cbg_pkg::BLANK_10_CYC, cbg_pkg::BLANK_11_CYC};
	int failures = 0;
	int tests_run = 0;
	int n;

	cbg_guard cbg_guard_inst (.clk_in(clk_in), .rst_in(rst_in),
		.blank_select_low_bit_in(bl), .blank_select_high_bit_in(bh),
		.driver_disable_input_in(dis), .coil_a_polarity_in(pa), .coil_b_polarity_in(pb),
		.coil_a_mixed_decay_off_in(da), .coil_b_mixed_decay_off_in(db),
		.serial_dir_a_in(1'h0), .serial_dir_b_in(sdb), .cmd_valid_in(cv),
		.cmd_both_zero_in(cz), .osc_tick_in(osc), .chop_cmp_a_in(cha),
		.chop_cmp_b_in(chb), .coil_a_sense_input_in(sa), .coil_b_sense_input_in(sb),
		.high_side_sense_node_in(hs), .overtemp_in(ot), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
		.drive_a_out(dra), .drive_b_out(drb), .mixed_decay_a_out(ma),
		.mixed_decay_b_out(mb), .status_out(st));

	cbg_bridge_model cbg_bridge_model_inst (.on_a_in(dra.on), .on_b_in(drb.on),
		.fault_a_in(fa), .fault_b_in(fb), .fault_hs_in(fh), .sense_a_out(sa),
		.sense_b_out(sb), .hs_out(hs), .decay_off_a_out(da), .decay_off_b_out(db));

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	always #50 clk_in = ~clk_in;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk_in);
		rd <= 1'h0;
		#1;
		chk("rdata", rdat & m, e);
	endtask

	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wd <= d;
		wr <= 1'h1;
		@(posedge clk_in);
		wr <= 1'h0;
	endtask

	task automatic tick();
		@(posedge clk_in);
		osc <= 1'h1;
		@(posedge clk_in);
		osc <= 1'h0;
		#1;
	endtask

	// fault after a 6-cycle blank; w: 0 a, 1 b, 2 high side
	task automatic fault(input int w);
		tick();
		repeat (6) @(posedge clk_in);
		fa <= (w == 0);
		fb <= (w == 1);
		fh <= (w == 2);
		@(posedge clk_in);
		{fa, fb, fh} <= 3'h0;
		#1;
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		#2000000;
		failures++;
		finish_test();
	end

	initial begin
		repeat (3) @(posedge clk_in);
		rst_in <= 1'h0;
		rdc(cbg_pkg::CTRL_OFS, 32'hffffffff, 32'h0);
		rdc(8'h0c, 32'hffffffff, 32'h0);
		chk("mixed_a", ma, 1'h0);
		chk("mixed_b", mb, 1'h0);
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_in);
			{bh, bl} <= 2'(s);
			cyc(2);
			tick();
			n = 0;
			while (dra.blank === 1'h1 && n < 40) begin
				n++;
				cyc(1);
			end
			chk("blank_len", 32'(n), 32'(blen[s]));
		end
		tick();
		@(posedge clk_in);
		{cha, chb} <= 2'h3;
		@(posedge clk_in);
		{cha, chb} <= 2'h0;
		#1;
		chk("chop_end_blank", {dra.chop_end, drb.chop_end}, 2'h0);
		repeat (15) @(posedge clk_in);
		{cha, chb} <= 2'h3;
		@(posedge clk_in);
		{cha, chb} <= 2'h0;
		#1;
		chk("chop_end", {dra.chop_end, drb.chop_end}, 2'h3);
		@(posedge clk_in);
		{bh, bl} <= 2'h0;
		tick();
		@(posedge clk_in);
		fa <= 1'h1;
		fh <= 1'h1;
		repeat (2) @(posedge clk_in);
		{fa, fh} <= 2'h0;
		#1;
		chk("on_a_blank", dra.on, 1'h1);
		chk("on_b_blank", drb.on, 1'h1);
		rdc(cbg_pkg::ERRCNT_OFS, 32'h3f, 32'h0);
		fault(0);
		chk("on_a_oc", dra.on, 1'h0);
		chk("on_b_oc", drb.on, 1'h1);
		cyc(3);
		chk("on_a_rest", dra.on, 1'h0);
		rdc(cbg_pkg::ERRCNT_OFS, 32'h3f, 32'h1);
		repeat (63) tick();
		chk("on_a_tick", dra.on, 1'h1);
		rdc(cbg_pkg::ERRCNT_OFS, 32'h3f, 32'h1);
		tick();
		rdc(cbg_pkg::ERRCNT_OFS, 32'h3f, 32'h0);
		fault(2);
		chk("hs_off_a", dra.on, 1'h0);
		chk("hs_off_b", drb.on, 1'h0);
		rdc(cbg_pkg::ERRCNT_OFS, 32'h3f, 32'h10);
		tick();
		@(posedge clk_in);
		ot <= 1'h1;
		cyc(2);
		chk("ot_off", {dra.on, drb.on, st.overtemp}, 3'h1);
		@(posedge clk_in);
		ot <= 1'h0;
		cyc(2);
		chk("ot_resume", {dra.on, drb.on, st.overtemp}, 3'h6);
		repeat (3) fault(0);
		rdc(cbg_pkg::STATUS_OFS, 32'h7f, 32'h11);
		rdc(cbg_pkg::ERRCNT_OFS, 32'h3, 32'h0);
		repeat (62) tick();
		chk("lock_a", {dra.on, drb.on}, 2'h1);
		tick();
		chk("unlock_a", dra.on, 1'h1);
		@(posedge clk_in);
		dis <= 1'h1;
		cyc(2);
		chk("dis_off", {dra.on, drb.on}, 2'h0);
		@(posedge clk_in);
		dis <= 1'h0;
		cyc(2);
		chk("dis_clear", {st.err_flag, dra.on}, 4'h1);
		repeat (3) fault(1);
		chk("flag_b", st.err_flag, 3'h2);
		fault(2);
		chk("hs_one_bridge", {dra.on, drb.on}, 2'h0);
		rdc(cbg_pkg::ERRCNT_OFS, 32'h30, 32'h10);
		@(posedge clk_in);
		cv <= 1'h1;
		@(posedge clk_in);
		cv <= 1'h0;
		cyc(2);
		chk("cmd_nonzero", st.err_flag, 3'h2);
		@(posedge clk_in);
		cv <= 1'h1;
		cz <= 1'h1;
		@(posedge clk_in);
		cv <= 1'h0;
		cyc(2);
		chk("cmd_zero", st.err_flag, 3'h0);
		wrr(cbg_pkg::CTRL_OFS, 32'h1);
		rdc(cbg_pkg::CTRL_OFS, 32'hffffffff, 32'h1);
		@(posedge clk_in);
		pa <= 1'h1;
		cyc(2);
		chk("dir_stand", {dra.dir, drb.dir}, 2'h2);
		wrr(cbg_pkg::CTRL_OFS, 32'h0);
		cyc(2);
		chk("dir_serial", {dra.dir, drb.dir}, 2'h1);
		finish_test();
	end
endmodule
